// File: rtl/cvs_video_serializer.sv
// Purpose: Per-core video serializer: frame handoff, pixel shifting, pin steering
// Assumes: PLL clocks are slow beside clk and sampled as levels through synchronisers
// Notes: Notes on behaviour follow
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.

`timescale 1ns/100ps
`default_nettype none

module cvs_video_serializer (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic video_pll_clock,
    input wire logic carrier_pll_clock,
    input wire logic [7:0] aural_pll_clocks,
    input wire logic handoff_req,
    input wire logic [31:0] colour_bus,
    input wire logic [31:0] pixel_bus,
    output logic handoff_ack,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe_n
);
    import cvs_pkg::*;

    // Software registers
    cvs_config_t cfg_reg; // Video configuration
    cvs_scale_t scl_reg; // Video scale
    logic [31:0] rdata_reg; // Read data, valid the cycle after a read

    // Synchronisers for the PLL pins
    logic vpll_s1_reg, vpll_s2_reg, vpll_s3_reg;
    logic cpll_s1_reg, cpll_s2_reg;
    logic [7:0] aur_s1_reg, aur_s2_reg;

    // Frame state
    logic [31:0] colours_reg; // Latched colour long
    logic [31:0] pixels_reg; // Latched pixel long
    logic [8:0] pix_cnt_reg, pix_cnt_next; // Clocks left in this pixel
    logic [12:0] frame_cnt_reg, frame_cnt_next; // Clocks left in this frame
    logic [4:0] pix_idx_reg, pix_idx_next; // Pixel being shown
    logic [3:0] phase_reg; // Chroma phase accumulator
    logic ack_reg; // Handoff completion pulse
    logic [31:0] pin_out_reg; // Pin levels
    logic [31:0] pin_oe_n_reg; // Pin drive enables, low drives

    // Rising edge of the synchronised video PLL marks one video clock
    // Limitation: the PLL must stay at each level for one clk or more,
    // otherwise a pulse slips between samples and a video clock is lost
    wire logic video_tick = vpll_s2_reg & ~vpll_s3_reg;

    // Register decode
    // Writes to the status address fall through and change nothing
    wire logic sel_config = (reg_addr == ADDR_CONFIG);
    wire logic sel_scale = (reg_addr == ADDR_SCALE);
    wire logic sel_status = (reg_addr == ADDR_STATUS);

    // Zero periods stand for the full count
    // One extra counter bit holds 256 and 4096, so the zero case needs no
    // special path in the down-counters
    wire logic [8:0] pix_reload = (scl_reg.pixel_period == '0) ? PIX_ZERO_RELOAD
                                  : {1'b0, scl_reg.pixel_period};
    wire logic [12:0] frame_reload = (scl_reg.frame_period == '0) ? FRAME_ZERO_RELOAD
                                     : {1'b0, scl_reg.frame_period};

    // Boundary and pixel step on a video clock
    // Counts run down to one, so a period of N spans exactly N video clocks
    // and the boundary edge reloads instead of decrementing
    wire logic frame_end = video_tick & (frame_cnt_reg == FRAME_LAST_COUNT);
    wire logic pixel_end = video_tick & (pix_cnt_reg == PIX_LAST_COUNT);

    // Last index depends on colour depth; beyond it the top pixel repeats
    wire logic [4:0] idx_last = cfg_reg.colour_depth ? IDX_LAST_FOUR_COLOUR
                                : IDX_LAST_TWO_COLOUR;
    wire logic idx_at_last = (pix_idx_reg >= idx_last);

    // Pixel value: 2 bits in four-colour, 1 bit in two-colour
    // Two-colour mode reaches only bytes 0 and 1 of the colour long
    wire logic [1:0] pix_val = cfg_reg.colour_depth ? pixels_reg[{pix_idx_reg[3:0], 1'b0} +: 2]
                               : {1'b0, pixels_reg[pix_idx_reg]};
    wire logic [7:0] colour_byte = colours_reg[{pix_val, 3'b000} +: 8];

    // Composite byte fields
    // Accumulator plus the byte's phase places the swing within the burst
    // period; the top bit of the sum chooses up or down
    wire logic [2:0] luma = colour_byte[LUMA_LSB +: 3];
    wire logic mod_on = colour_byte[MOD_BIT];
    wire logic [3:0] phase = colour_byte[PHASE_LSB +: 4];
    wire logic [3:0] phase_sum = phase_reg + phase;
    wire logic swing_up = phase_sum[3]; // Half of each burst period is the upper swing
    wire logic [3:0] luma_up = {1'b0, luma} + LUMA_STEP;
    // Clamp at black so the low swing never wraps to white
    wire logic [3:0] luma_dn = (luma == '0) ? LUMA_FLOOR : ({1'b0, luma} - LUMA_STEP);
    wire logic [3:0] luma_mod = swing_up ? luma_up : luma_dn;

    // Each composite signal carries chroma only if its enable is set
    wire logic [3:0] base_val = (mod_on & cfg_reg.baseband_chroma_en) ? luma_mod
                                : {1'b0, luma};
    wire logic [3:0] bcast_lvl = (mod_on & cfg_reg.broadcast_chroma_en) ? luma_mod
                                 : {1'b0, luma};

    // Broadcast: carrier keyed by the level, audio sub-carrier mixed in
    // Trade-off: audio is mixed by exclusive-or, a crude stand-in for
    // frequency modulation that keeps the mixer to one gate
    wire logic aural = aur_s2_reg[cfg_reg.aural_source_sel];
    wire logic carrier = cpll_s2_reg ^ aural;
    wire logic [3:0] bcast_val = carrier ? bcast_lvl : '0;

    // Byte for the selected output type
    logic [7:0] video_byte;
    always_comb begin
        // Output type decode
        case (cfg_reg.output_type)
            OUT_DISABLED: video_byte = '0;
            OUT_VGA: video_byte = colour_byte;
            OUT_COMP_BCAST_HI: video_byte = {bcast_val, base_val};
            OUT_COMP_BCAST_LO: video_byte = {base_val, bcast_val};
            default: video_byte = '0;
        endcase
    end

    // Steering to a group of eight pins through the mask
    // Reserved group codes drive nothing rather than alias onto a real
    // group, so future codes cannot disturb pins in use
    wire logic group_ok = (cfg_reg.pin_group_sel <= GROUP_LAST);
    wire logic video_on = (cfg_reg.output_type != OUT_DISABLED) & group_ok;
    wire logic [4:0] group_shift = {cfg_reg.pin_group_sel[1:0], 3'b000};
    wire logic [31:0] pins_val = {24'h00_0000, video_byte} << group_shift;
    wire logic [31:0] pins_drv = video_on ? ({24'h00_0000, cfg_reg.pin_output_mask} << group_shift)
                                 : '0;

    // Status word: index, live counts and whether the video PLL is seen
    // Layout: [28] PLL level, [27] waiting core, [26:22] index, [21:13] pixel, [12:0] frame
    wire logic [31:0] status_word = {3'b000, vpll_s2_reg, handoff_req, pix_idx_reg,
                                     pix_cnt_reg, frame_cnt_reg};

    // Read mux; unmapped addresses read zero
    wire logic [31:0] read_mux = sel_config ? cfg_reg
                                 : sel_scale ? scl_reg
                                 : sel_status ? status_word : '0;

    // Next counter state
    // A boundary outranks a pixel step that lands on the same video clock
    always_comb begin
        pix_cnt_next = pix_cnt_reg;
        frame_cnt_next = frame_cnt_reg;
        pix_idx_next = pix_idx_reg;
        if (frame_end) begin
            // New frame: both counts reload, shifting restarts at pixel zero
            pix_cnt_next = pix_reload;
            frame_cnt_next = frame_reload;
            pix_idx_next = IDX_FIRST;
        end else if (video_tick) begin
            frame_cnt_next = frame_cnt_reg - FRAME_LAST_COUNT;
            if (pixel_end) begin
                pix_cnt_next = pix_reload;
                // Hold at the top pixel once the long is spent
                if (!idx_at_last) begin
                    pix_idx_next = pix_idx_reg + 5'h01;
                end
            end else begin
                pix_cnt_next = pix_cnt_reg - PIX_LAST_COUNT;
            end
        end
    end

    // Register writes; reserved bits stay zero
    // New scale values only take hold at the next reload
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reg <= CONFIG_RST;
            scl_reg <= SCALE_RST;
        end else if (reg_wr) begin
            if (sel_config) begin
                cfg_reg <= reg_wdata & CONFIG_WMASK;
            end
            if (sel_scale) begin
                scl_reg <= reg_wdata & SCALE_WMASK;
            end
        end
    end

    // Read data for exactly one cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= reg_rd ? read_mux : '0;
        end
    end

    // Two-flop synchronisers; the third video flop only feeds the edge detect
    // Reset to the idle low level so release makes no false video clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vpll_s1_reg <= 1'b0;
            vpll_s2_reg <= 1'b0;
            vpll_s3_reg <= 1'b0;
            cpll_s1_reg <= 1'b0;
            cpll_s2_reg <= 1'b0;
            aur_s1_reg <= '0;
            aur_s2_reg <= '0;
        end else begin
            vpll_s1_reg <= video_pll_clock;
            vpll_s2_reg <= vpll_s1_reg;
            vpll_s3_reg <= vpll_s2_reg;
            cpll_s1_reg <= carrier_pll_clock;
            cpll_s2_reg <= cpll_s1_reg;
            aur_s1_reg <= aural_pll_clocks;
            aur_s2_reg <= aur_s1_reg;
        end
    end

    // Counters; first video clock after reset is a boundary
    // That first boundary latches a frame at once, waiting core or not
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pix_cnt_reg <= PIX_LAST_COUNT;
            frame_cnt_reg <= FRAME_LAST_COUNT;
            pix_idx_reg <= IDX_FIRST;
        end else begin
            pix_cnt_reg <= pix_cnt_next;
            frame_cnt_reg <= frame_cnt_next;
            pix_idx_reg <= pix_idx_next;
        end
    end

    // Frame latch: buses are taken whether or not the core is waiting
    // Hazard: a late core shows whatever sits on its operand buses for a
    // whole frame, with no acknowledge to tell it so
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            colours_reg <= '0;
            pixels_reg <= '0;
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= frame_end & handoff_req;
            if (frame_end) begin
                colours_reg <= colour_bus;
                pixels_reg <= pixel_bus;
            end
        end
    end

    // Chroma phase steps once per video clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= '0;
        end else if (video_tick) begin
            phase_reg <= phase_reg + 4'h1;
        end
    end

    // Registered pins
    // Undriven pins are forced low so a later enable shows no stale level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out_reg <= '0;
            pin_oe_n_reg <= PIN_DRIVE_N_RST;
        end else begin
            pin_out_reg <= pins_val & pins_drv;
            pin_oe_n_reg <= ~pins_drv;
        end
    end

    assign reg_rdata = rdata_reg;
    assign handoff_ack = ack_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe_n = pin_oe_n_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_DISABLED_NO_DRIVE: assert property (
        $past(cfg_reg.output_type) == OUT_DISABLED |-> pin_oe_n_reg == PIN_DRIVE_N_RST)
        else $error("pins driven while video disabled");

    AST_RESERVED_GROUP: assert property (
        $past(cfg_reg.pin_group_sel) > GROUP_LAST |-> pin_oe_n_reg == PIN_DRIVE_N_RST)
        else $error("reserved pin group drove pins");

    AST_MASK_SUBSET: assert property (
        ((~pin_oe_n_reg) & ~({24'h00_0000, $past(cfg_reg.pin_output_mask)}
            << {$past(cfg_reg.pin_group_sel[1:0]), 3'b000})) == '0)
        else $error("pin driven outside mask");

    AST_VGA_BYTE: assert property (
        $past(cfg_reg.output_type == OUT_VGA && cfg_reg.pin_group_sel == '0
              && cfg_reg.pin_output_mask == 8'hff)
        |-> pin_out_reg[7:0] == $past(colour_byte))
        else $error("VGA byte altered on pins");

    AST_FRAME_RELOAD: assert property (
        frame_end |=> pix_idx_reg == IDX_FIRST && pix_cnt_reg == $past(pix_reload)
                      && frame_cnt_reg == $past(frame_reload))
        else $error("boundary did not reload counters");

    AST_BUS_LATCH: assert property (
        frame_end |=> pixels_reg == $past(pixel_bus) && colours_reg == $past(colour_bus))
        else $error("boundary did not latch buses");

    AST_ACK_CAUSE: assert property (
        handoff_ack |-> $past(frame_end) && $past(handoff_req))
        else $error("handoff acknowledged off boundary");

    AST_IDX_SATURATE: assert property (
        pixel_end && !frame_end && idx_at_last |=> $stable(pix_idx_reg))
        else $error("index moved past last pixel");

    AST_PIX_ADVANCE: assert property (
        pixel_end && !frame_end && !idx_at_last |=> pix_idx_reg == $past(pix_idx_reg) + 5'h01)
        else $error("pixel did not advance");

    AST_ZERO_PERIOD: assert property (
        pixel_end && !frame_end && scl_reg.pixel_period == '0 |=> pix_cnt_reg == PIX_ZERO_RELOAD)
        else $error("zero pixel period not 256");

    AST_READ_ONE_CYCLE: assert property (
        !$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside its cycle");

    AST_UNDRIVEN_LOW: assert property (
        (pin_out_reg & pin_oe_n_reg) == '0)
        else $error("undriven pin shows a high level");

    AST_ACK_PULSE: assert property (
        handoff_ack |=> !handoff_ack)
        else $error("handoff acknowledge longer than one cycle");

    AST_PLAIN_LUMA: assert property (
        $past(cfg_reg.output_type == OUT_COMP_BCAST_LO && cfg_reg.pin_group_sel == '0
              && cfg_reg.pin_output_mask == 8'hff && !mod_on)
        |-> pin_out_reg[7:4] == {1'b0, $past(luma)})
        else $error("luminance altered with modulation off");

    AST_TWO_COLOUR_LOW: assert property (
        !cfg_reg.colour_depth |-> pix_val[1] == 1'b0)
        else $error("two-colour pixel reached an upper colour byte");

    COV_HANDOFF: cover property (frame_end && handoff_req);
    COV_NO_HANDOFF: cover property (frame_end && !handoff_req);
    COV_REPEAT_TOP: cover property (pixel_end && idx_at_last && !frame_end);
    COV_COMPOSITE: cover property (cfg_reg.output_type == OUT_COMP_BCAST_HI && mod_on);

endmodule : cvs_video_serializer

`default_nettype wire

// File: rtl/cvs_pkg.sv
// Purpose: Shared constants and carriers for the video serializer
// Assumes: One system clock; video and carrier PLL clocks arrive as levels
// Notes: Register offsets are byte addresses on the plain register port

package cvs_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_SCALE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // Output type codes
    localparam logic [1:0] OUT_DISABLED = 2'h0;
    localparam logic [1:0] OUT_VGA = 2'h1;
    localparam logic [1:0] OUT_COMP_BCAST_HI = 2'h2;
    localparam logic [1:0] OUT_COMP_BCAST_LO = 2'h3;

    // Pin groups above this code are reserved
    localparam logic [2:0] GROUP_LAST = 3'h3;

    // Counter figures
    localparam logic [8:0] PIX_ZERO_RELOAD = 9'h100;
    localparam logic [12:0] FRAME_ZERO_RELOAD = 13'h1000;
    localparam logic [8:0] PIX_LAST_COUNT = 9'h001;
    localparam logic [12:0] FRAME_LAST_COUNT = 13'h0001;
    localparam logic [4:0] IDX_LAST_TWO_COLOUR = 5'h1f;
    localparam logic [4:0] IDX_LAST_FOUR_COLOUR = 5'h0f;
    localparam logic [4:0] IDX_FIRST = 5'h00;

    // Composite colour byte layout
    localparam int LUMA_LSB = 0;
    localparam int MOD_BIT = 3;
    localparam int PHASE_LSB = 4;
    localparam logic [3:0] LUMA_STEP = 4'h1;
    localparam logic [3:0] LUMA_FLOOR = 4'h0;

    // Reset values
    localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
    localparam logic [31:0] SCALE_RST = 32'h0000_0000;
    localparam logic [31:0] PIN_DRIVE_N_RST = 32'hffff_ffff;

    // Configuration register layout
    typedef struct packed {
        logic rsv_top;             // Bit 31, reads zero
        logic [1:0] output_type;   // Bits 30:29
        logic colour_depth;        // Bit 28
        logic broadcast_chroma_en; // Bit 27
        logic baseband_chroma_en;  // Bit 26
        logic [2:0] aural_source_sel; // Bits 25:23
        logic [10:0] rsv_mid;      // Bits 22:12, read zero
        logic [2:0] pin_group_sel; // Bits 11:9
        logic rsv_low;             // Bit 8, reads zero
        logic [7:0] pin_output_mask; // Bits 7:0
    } cvs_config_t;

    // Scale register layout
    typedef struct packed {
        logic [11:0] rsv_top;      // Bits 31:20, read zero
        logic [7:0] pixel_period;  // Bits 19:12
        logic [11:0] frame_period; // Bits 11:0
    } cvs_scale_t;

    // Writable bits of each register
    localparam logic [31:0] CONFIG_WMASK = 32'h7f80_0eff;
    localparam logic [31:0] SCALE_WMASK = 32'h000f_ffff;

endpackage : cvs_pkg

// File: tb/cvs_core_model.sv
// Purpose: Owning-core model that runs the video PLL and hands frames over
// Assumes: Handoff port shares clk with the serializer
// Notes: Released operand buses show the inverse of the last value

`timescale 1ns/100ps
`default_nettype none

module cvs_core_model (
    input wire logic clk,
    input wire logic handoff_ack,
    output logic video_pll_clock,
    output logic handoff_req,
    output logic [31:0] colour_bus,
    output logic [31:0] pixel_bus
);
    logic run = 1'b0; // PLL running flag
    logic [1:0] div = 2'h0; // Half-period count

    // Idle levels at time zero
    initial begin
        video_pll_clock = 1'b0;
        handoff_req = 1'b0;
        colour_bus = 32'h0000_0000;
        pixel_bus = 32'h0000_0000;
    end

    // Four clk per half period, slow enough for the edge detector
    always @(posedge clk) begin
        div <= run ? div + 2'h1 : 2'h0;
        if (!run) video_pll_clock <= 1'b0;
        else if (div == 2'h3) video_pll_clock <= ~video_pll_clock;
    end

    // PLL goes first, before any handoff is tried
    task automatic start_pll();
        @(posedge clk);
        run <= 1'b1;
    endtask : start_pll

    // Stopped PLL stays low
    task automatic stop_pll();
        run <= 1'b0;
    endtask : stop_pll

    // Wait in handoff and hold both longs until taken
    task automatic hand(input logic [31:0] c, input logic [31:0] p, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        handoff_req <= 1'b1;
        colour_bus <= c;
        pixel_bus <= p;
        while (handoff_ack !== 1'b1 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        ok = (n < 40000);
        handoff_req <= 1'b0;
        colour_bus <= ~c;
        pixel_bus <= ~p;
    endtask : hand

    // Operand buses change with no handoff pending
    task automatic put(input logic [31:0] c, input logic [31:0] p);
        @(posedge clk);
        colour_bus <= c;
        pixel_bus <= p;
    endtask : put
endmodule : cvs_core_model

`default_nettype wire

// File: tb/cvs_video_serializer_tb_top.sv
// Purpose: Self-checking bench for the video serializer
// Assumes: Video PLL tick every 8 clk from the core model
// Notes: Each scenario resets the block and programs it afresh

`timescale 1ns/100ps
`default_nettype none

module cvs_video_serializer_tb_top;
    import cvs_pkg::*;
    logic clk, arst_n, reg_wr, reg_rd, carrier_pll_clock, handoff_ack, video_pll_clock, handoff_req;
    logic [7:0] reg_addr, aural_pll_clocks;
    logic [31:0] reg_wdata, reg_rdata, colour_bus, pixel_bus, pin_out, pin_oe_n;
    int errors = 0, compares = 0, cyc = 0, acks = 0;

    cvs_video_serializer u_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .video_pll_clock(video_pll_clock),
        .carrier_pll_clock(carrier_pll_clock), .aural_pll_clocks(aural_pll_clocks),
        .handoff_req(handoff_req), .colour_bus(colour_bus), .pixel_bus(pixel_bus),
        .handoff_ack(handoff_ack), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    cvs_core_model u_core (.clk(clk), .handoff_ack(handoff_ack), .video_pll_clock(video_pll_clock),
        .handoff_req(handoff_req), .colour_bus(colour_bus), .pixel_bus(pixel_bus));

    // 100 ns system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Cycle and ack counters
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (handoff_ack === 1'b1) acks <= acks + 1;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Either of two levels is right, as for a chroma swing
    task automatic chk2(input string nm, input logic [3:0] a, input logic [3:0] b, input logic [3:0] g);
        compares++;
        if (g !== a && g !== b) begin
            errors++;
            $display("[ERR] %s expected %h or %h seen %h", nm, a, b, g);
        end
    endtask : chk2

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk("reg_rdata", e, reg_rdata);
    endtask : rd

    function automatic logic [31:0] cfg(input logic [1:0] md, input logic d, input logic bc, input logic cc,
        input logic [2:0] au, input logic [2:0] g, input logic [7:0] m);
        return {1'b0, md, d, bc, cc, au, 11'h000, g, 1'b0, m};
    endfunction : cfg

    function automatic logic [31:0] scl(input logic [7:0] pp, input logic [11:0] fp);
        return {12'h000, pp, fp};
    endfunction : scl

    // Colour byte for pixel i; last pixel repeats past the long
    function automatic logic [7:0] pick(input logic [31:0] c, input logic [31:0] p, input logic d, input int i);
        int k;
        k = d ? (i > 15 ? 15 : i) : (i > 31 ? 31 : i);
        return d ? c[8 * p[2 * k +: 2] +: 8] : c[8 * p[k] +: 8];
    endfunction : pick

    task automatic do_reset();
        u_core.stop_pll();
        arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset

    // PLL, then scale, then config; both writes land before the first video clock
    task automatic setup(input logic [31:0] c, input logic [31:0] s);
        do_reset();
        u_core.start_pll();
        wr(ADDR_SCALE, s);
        wr(ADDR_CONFIG, c);
    endtask : setup

    // Sample mid-pixel; frame f0 for npf pixels, then frame f1
    task automatic vga_run(input logic [2:0] g, input logic [7:0] m, input logic d, input int stp, input int npf,
        input int n, input logic [31:0] c0, input logic [31:0] p0, input logic [31:0] c1, input logic [31:0] p1);
        logic [7:0] b;
        repeat (3) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            if (i > 0) repeat (stp) @(posedge clk);
            b = i < npf ? pick(c0, p0, d, i) : pick(c1, p1, d, i - npf);
            chk("pin_out", {24'h00_0000, b & m} << (8 * g), pin_out);
            chk("pin_oe_n", ~({24'h00_0000, m} << (8 * g)), pin_oe_n);
        end
    endtask : vga_run

    task automatic test_regs();
        do_reset();
        chk("pin_oe_n", 32'hffff_ffff, pin_oe_n);
        rd(ADDR_CONFIG, 32'h0000_0000);
        rd(ADDR_SCALE, 32'h0000_0000);
        wr(ADDR_CONFIG, 32'hffff_ffff);
        wr(ADDR_SCALE, 32'hffff_ffff);
        rd(ADDR_CONFIG, 32'h7f80_0eff);
        rd(ADDR_SCALE, 32'h000f_ffff);
        rd(8'h0c, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_2001);
        $display("test_regs done, errors %0d", errors);
    endtask : test_regs

    // Four colours, group 2, sparse mask, then reserved group and disable
    task automatic test_vga4();
        logic ok;
        int t;
        setup(cfg(2'h1, 1'b1, 1'b0, 1'b0, 3'h0, 3'h2, 8'ha5), scl(8'h01, 12'h014));
        u_core.hand(32'hff96_5ac3, 32'he4e4_1b1b, ok);
        t = cyc;
        chk("handoff_ack", 1, ok);
        vga_run(3'h2, 8'ha5, 1'b1, 8, 20, 20, 32'hff96_5ac3, 32'he4e4_1b1b, 0, 0);
        u_core.hand(32'h0102_0304, 32'h0000_0000, ok);
        chk("frame_clocks", 20 * 8, cyc - t);
        chk("handoff_ack", 1, ok);
        wr(ADDR_CONFIG, cfg(2'h1, 1'b1, 1'b0, 1'b0, 3'h0, 3'h4, 8'hff));
        repeat (3) @(posedge clk);
        chk("pin_oe_n", 32'hffff_ffff, pin_oe_n);
        wr(ADDR_CONFIG, cfg(2'h0, 1'b1, 1'b0, 1'b0, 3'h0, 3'h1, 8'hff));
        repeat (3) @(posedge clk);
        chk("pin_oe_n", 32'hffff_ffff, pin_oe_n);
        $display("test_vga4 done, errors %0d", errors);
    endtask : test_vga4

    // Two colours, group 3; next frame latched with no handoff pending
    task automatic test_vga2();
        logic ok;
        int a;
        setup(cfg(2'h1, 1'b0, 1'b0, 1'b0, 3'h0, 3'h3, 8'h0f), scl(8'h02, 12'h042));
        u_core.hand(32'h0000_a53c, 32'h8765_4321, ok);
        chk("handoff_ack", 1, ok);
        u_core.put(32'h0000_6996, 32'hffff_fffe);
        a = acks;
        vga_run(3'h3, 8'h0f, 1'b0, 16, 33, 35, 32'h0000_a53c, 32'h8765_4321, 32'h0000_6996, 32'hffff_fffe);
        chk("handoff_ack", a, acks);
        $display("test_vga2 done, errors %0d", errors);
    endtask : test_vga2

    // Composite both orders, broadcast chroma only, aural mixing
    task automatic test_comp();
        logic ok;
        setup(cfg(2'h2, 1'b0, 1'b1, 1'b0, 3'h0, 3'h0, 8'hff), scl(8'h01, 12'h040));
        carrier_pll_clock <= 1'b1;
        u_core.hand(32'h0000_f53d, 32'hffff_0000, ok);
        chk("handoff_ack", 1, ok);
        for (int i = 0; i < 8; i++) begin
            repeat (8) @(posedge clk);
            chk2("broadcast", 4'h4, 4'h6, pin_out[7:4]);
            chk("baseband", 5, pin_out[3:0]);
        end
        chk("pin_oe_n", 32'hffff_ff00, pin_oe_n);
        aural_pll_clocks <= 8'h01;
        repeat (8) @(posedge clk);
        chk("broadcast", 0, pin_out[7:4]);
        aural_pll_clocks <= 8'h00;
        wr(ADDR_CONFIG, cfg(2'h3, 1'b0, 1'b1, 1'b0, 3'h0, 3'h0, 8'hff));
        repeat (8) @(posedge clk);
        chk2("broadcast", 4'h4, 4'h6, pin_out[3:0]);
        chk("baseband", 5, pin_out[7:4]);
        repeat (60) @(posedge clk);
        chk("broadcast", 5, pin_out[3:0]);
        carrier_pll_clock <= 1'b0;
        $display("test_comp done, errors %0d", errors);
    endtask : test_comp

    // Zero periods stand for 256 and 4096 video clocks
    task automatic test_zero();
        logic ok;
        int t;
        setup(cfg(2'h1, 1'b0, 1'b0, 1'b0, 3'h0, 3'h1, 8'hff), scl(8'h00, 12'h000));
        u_core.hand(32'h0000_c35a, 32'h0000_0002, ok);
        chk("handoff_ack", 1, ok);
        t = cyc;
        repeat (3 + 255 * 8) @(posedge clk);
        chk("pin_out", 32'h0000_5a00, pin_out);
        repeat (8) @(posedge clk);
        chk("pin_out", 32'h0000_c300, pin_out);
        u_core.hand(32'h0000_0000, 32'h0000_0000, ok);
        chk("frame_clocks", 4096 * 8, cyc - t);
        chk("handoff_ack", 1, ok);
        $display("test_zero done, errors %0d", errors);
    endtask : test_zero

    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // Main sequence
    initial begin
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        carrier_pll_clock = 1'b0;
        aural_pll_clocks = 8'h00;
        test_regs();
        test_vga4();
        test_vga2();
        test_comp();
        test_zero();
        print_verdict();
    end

    // Watchdog well past the expected 34k cycles
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("[ERR] watchdog expected done seen hang");
        print_verdict();
    end
endmodule : cvs_video_serializer_tb_top

`default_nettype wire
